// ===== include/brc_pkg.sv
package brc_pkg;

   // Brown-out mode field encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SW = 2'h1;
   localparam logic [1:0] MODE_NOSLEEP = 2'h2;
   localparam logic [1:0] MODE_ON = 2'h3;

   // Register byte offsets
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;

   // Control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SWEN_BIT = 2;
   localparam int CTRL_THR_LSB = 3;
   localparam int CTRL_POWER_UP_DELAY_TIMER_BIT = 5;
   localparam int THR_W = 2;

   // Status register fields
   localparam int STAT_POR_BIT = 0;
   localparam int STAT_BOR_BIT = 1;
   localparam int STAT_RDY_BIT = 2;
   localparam int STAT_ABORT_BIT = 3;
   localparam int STAT_STATE_LSB = 4;

   // Reset values
   localparam logic [1:0] MODE_RST = 2'h3;
   localparam logic SWEN_RST = 1'b0;
   localparam logic [THR_W-1:0] THR_RST = 2'h0;
   localparam logic [THR_W-1:0] THR_LOWEST = 2'h0;
   localparam logic POWER_UP_DELAY_TIMER_EN_RST = 1'b0;
   localparam logic POR_FLAG_RST = 1'b0;
   localparam logic BOR_FLAG_RST = 1'b1;

   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int BOR_FILTER_NS = 1000;
   localparam int BOR_FILTER_CYC = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWER_UP_DELAY_TIMER_NS = 64000000;
   localparam int POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_NS / CLK_PERIOD_NS;
   localparam int POWER_UP_DELAY_TIMER_W = 21;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_HOLD = 3'h0,
      ST_BOOT = 3'h1,
      ST_POWER_UP_DELAY_TIMER = 3'h2,
      ST_RUN = 3'h3,
      ST_SLEEP = 3'h4,
      ST_WAKE = 3'h5
   } brc_state_t;

endpackage

// ===== hw/brc_glitch_filter.sv
module brc_glitch_filter
   import brc_pkg::*;
#(
   parameter int CYCLES = BOR_FILTER_CYC
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Raw and filtered level
   input wire logic below,
   output logic trip
);

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CYCLES);

   logic [CNT_W-1:0] cnt_r;

   // Count cycles spent below; any rise restarts the count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
      end
      else if (!below)
      begin
         cnt_r <= '0;
      end
      else if (cnt_r != CNT_MAX)
      begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Trip only once the dip outlasts the filter time
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trip <= 1'b0;
      end
      else
      begin
         trip <= below && (cnt_r == CNT_MAX);
      end
   end

endmodule

// ===== hw/brc_brownout_reset_control.sv
//Contract
// - A power-on reset clears the power-on status flag to zero.
// - A brown-out reset clears the brown-out status flag to zero.
// - Mode field: 11 on, 10 off in sleep, 01 software, 00 off.
// - Modes 11 and 10 hold start-up until detector ready and supply good.
// - Mode 11 keeps protection in sleep; wake-up is immediate.
// - Mode 10 hibernates detector in sleep; wake-up waits for ready.
// - Mode 01 follows software enable; start-up does not wait.
// - Software mode protects once ready; ready flag mirrors detector ready (here the flag is detector ready ANDed with detector enable).
// - Software mode ignores sleep; wake-up is immediate.
// - Mode 00 disables detector; start-up begins immediately.
// - Forced-on mode shows ready set before execution begins.
// - Dips shorter than the filter time cause no brown-out reset.
// - Bulk erase forces detector on at lowest threshold.
// - Supply drop during bulk erase aborts erase, no reset.
// - Low-power trip ORed with main trip forms generic brown-out.
//
// Design decisions made here: register access over APB and the placing of the registers.
module brc_brownout_reset_control
   import brc_pkg::*;
#(
   parameter int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_CYC
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Supply monitors
   input wire logic bor_below_thr,
   input wire logic bor_det_ready,
   input wire logic low_power_brownout,
   output logic bor_det_enable,
   output logic bor_det_hibernate,
   output logic [THR_W-1:0] bor_thr_sel,
   // CPU and memory control
   input wire logic sleep_req,
   input wire logic wake_req,
   input wire logic bulk_erase,
   output logic erase_abort,
   output logic cpu_run,
   output logic sys_reset_n
);

   brc_state_t state_r;
   brc_state_t state_nxt;

   logic [1:0] brownout_mode_cfg_r;
   logic sw_brownout_enable_r;
   logic [THR_W-1:0] thr_cfg_r;
   logic power_up_delay_timer_en_r;
   logic por_flag_r;
   logic brownout_flag_r;
   logic abort_flag_r;
   logic [POWER_UP_DELAY_TIMER_W-1:0] power_up_delay_timer_r;

   logic det_active;
   logic main_trip;
   logic bor_generic;
   logic bor_reset_evt;
   logic abort_evt;
   logic boot_ok;
   logic wr_ctrl;
   logic wr_stat;
   logic acc_start;
   logic acc_done;
   logic addr_ok;
   logic [31:0] rd_val;

   localparam logic [POWER_UP_DELAY_TIMER_W-1:0] POWER_UP_DELAY_TIMER_LOAD = POWER_UP_DELAY_TIMER_W'(POWER_UP_DELAY_TIMER_CYCLES - 1);

   // APB phase decode
   assign acc_start = psel && penable && !pready;
   assign acc_done = psel && penable && pready;
   assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT);
   assign wr_ctrl = acc_done && pwrite && (paddr == ADDR_CTRL);
   assign wr_stat = acc_done && pwrite && (paddr == ADDR_STAT);

   // Detector activity per mode
   always_comb
   begin
      det_active = 1'b0;
      unique case (brownout_mode_cfg_r)
         MODE_ON: det_active = 1'b1;
         MODE_NOSLEEP: det_active = (state_r != ST_SLEEP);
         MODE_SW: det_active = sw_brownout_enable_r;
         MODE_OFF: det_active = 1'b0;
      endcase
      if (bulk_erase)
      begin
         det_active = 1'b1;
      end
   end

   // Main detector, filtered, counts only once the detector is ready
   brc_glitch_filter #(
      .CYCLES(BOR_FILTER_CYC)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .below(bor_below_thr && bor_det_enable && bor_det_ready),
      .trip(main_trip)
   );

   assign bor_generic = main_trip || low_power_brownout;
   assign bor_reset_evt = bor_generic && !bulk_erase;
   assign abort_evt = bor_generic && bulk_erase;

   // Start-up gate per mode
   always_comb
   begin
      boot_ok = 1'b1;
      unique case (brownout_mode_cfg_r)
         MODE_ON, MODE_NOSLEEP: boot_ok = bor_det_ready && !bor_below_thr;
         MODE_SW, MODE_OFF: boot_ok = 1'b1;
      endcase
   end

   // Sequencer next state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_HOLD:
         begin
            if (!bor_generic)
            begin
               state_nxt = ST_BOOT;
            end
         end
         ST_BOOT:
         begin
            if (boot_ok)
            begin
               state_nxt = power_up_delay_timer_en_r ? ST_POWER_UP_DELAY_TIMER : ST_RUN;
            end
         end
         ST_POWER_UP_DELAY_TIMER:
         begin
            if (power_up_delay_timer_r == '0)
            begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (sleep_req)
            begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (wake_req)
            begin
               if (brownout_mode_cfg_r == MODE_NOSLEEP)
               begin
                  state_nxt = ST_WAKE;
               end
               else
               begin
                  state_nxt = ST_RUN;
               end
            end
         end
         ST_WAKE:
         begin
            if (bor_det_ready)
            begin
               state_nxt = ST_RUN;
            end
         end
         default:
         begin
            state_nxt = ST_HOLD;
         end
      endcase
      if (bor_reset_evt)
      begin
         state_nxt = ST_HOLD;
      end
   end

   // Sequencer state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ST_HOLD;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Power-up delay counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         power_up_delay_timer_r <= '0;
      end
      else if (state_r != ST_POWER_UP_DELAY_TIMER)
      begin
         power_up_delay_timer_r <= POWER_UP_DELAY_TIMER_LOAD;
      end
      else if (power_up_delay_timer_r != '0)
      begin
         power_up_delay_timer_r <= power_up_delay_timer_r - 1'b1;
      end
   end

   // Internal reset and run enable, released on a clock edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sys_reset_n <= 1'b0;
         cpu_run <= 1'b0;
      end
      else
      begin
         sys_reset_n <= (state_nxt == ST_RUN) || (state_nxt == ST_SLEEP)
                        || (state_nxt == ST_WAKE);
         cpu_run <= (state_nxt == ST_RUN);
      end
   end

   // Detector controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bor_det_enable <= 1'b0;
         bor_det_hibernate <= 1'b0;
         bor_thr_sel <= THR_RST;
      end
      else
      begin
         bor_det_enable <= det_active;
         bor_det_hibernate <= !det_active && (brownout_mode_cfg_r != MODE_OFF);
         bor_thr_sel <= bulk_erase ? THR_LOWEST : thr_cfg_r;
      end
   end

   // Erase abort pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         erase_abort <= 1'b0;
      end
      else
      begin
         erase_abort <= abort_evt;
      end
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         brownout_mode_cfg_r <= MODE_RST;
         sw_brownout_enable_r <= SWEN_RST;
         thr_cfg_r <= THR_RST;
         power_up_delay_timer_en_r <= POWER_UP_DELAY_TIMER_EN_RST;
      end
      else if (wr_ctrl)
      begin
         brownout_mode_cfg_r <= pwdata[CTRL_MODE_LSB +: 2];
         sw_brownout_enable_r <= pwdata[CTRL_SWEN_BIT];
         thr_cfg_r <= pwdata[CTRL_THR_LSB +: THR_W];
         power_up_delay_timer_en_r <= pwdata[CTRL_POWER_UP_DELAY_TIMER_BIT];
      end
   end

   // Cause flags: writing one sets them, hardware clear wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         por_flag_r <= POR_FLAG_RST;
      end
      else if (wr_stat && pwdata[STAT_POR_BIT])
      begin
         por_flag_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         brownout_flag_r <= BOR_FLAG_RST;
      end
      else if (bor_reset_evt)
      begin
         brownout_flag_r <= 1'b0;
      end
      else if (wr_stat && pwdata[STAT_BOR_BIT])
      begin
         brownout_flag_r <= 1'b1;
      end
   end

   // Sticky abort record: hardware set wins, write one clears
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         abort_flag_r <= 1'b0;
      end
      else if (abort_evt)
      begin
         abort_flag_r <= 1'b1;
      end
      else if (wr_stat && pwdata[STAT_ABORT_BIT])
      begin
         abort_flag_r <= 1'b0;
      end
   end

   // Read mux
   always_comb
   begin
      rd_val = '0;
      if (paddr == ADDR_CTRL)
      begin
         rd_val[CTRL_MODE_LSB +: 2] = brownout_mode_cfg_r;
         rd_val[CTRL_SWEN_BIT] = sw_brownout_enable_r;
         rd_val[CTRL_THR_LSB +: THR_W] = thr_cfg_r;
         rd_val[CTRL_POWER_UP_DELAY_TIMER_BIT] = power_up_delay_timer_en_r;
      end
      else if (paddr == ADDR_STAT)
      begin
         rd_val[STAT_POR_BIT] = por_flag_r;
         rd_val[STAT_BOR_BIT] = brownout_flag_r;
         rd_val[STAT_RDY_BIT] = bor_det_ready && bor_det_enable;
         rd_val[STAT_ABORT_BIT] = abort_flag_r;
         rd_val[STAT_STATE_LSB +: 3] = state_r;
      end
   end

   // APB answer, one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= acc_start;
         pslverr <= acc_start && !addr_ok;
         if (acc_start && !pwrite)
         begin
            prdata <= rd_val;
         end
      end
   end

endmodule

// ===== tb/brc_chk.sv
module brc_chk
   import brc_pkg::*;
(
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Supply side
   input wire logic bor_below_thr,
   input wire logic bor_det_ready,
   input wire logic low_power_brownout,
   input wire logic bor_det_enable,
   input wire logic bor_det_hibernate,
   input wire logic [THR_W-1:0] bor_thr_sel,
   // CPU side
   input wire logic wake_req,
   input wire logic bulk_erase,
   input wire logic erase_abort,
   input wire logic cpu_run,
   input wire logic sys_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] mode_r;
   logic swen_r;
   logic [4:0] low_r;

   // Shadow of the control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= MODE_RST;
         swen_r <= SWEN_RST;
      end
      else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
      begin
         mode_r <= pwdata[1:0];
         swen_r <= pwdata[CTRL_SWEN_BIT];
      end
   end

   // Consecutive qualified low samples
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_r <= 5'h00;
      else if (!(bor_below_thr && bor_det_enable && bor_det_ready))
         low_r <= 5'h00;
      else if (low_r != 5'h1F)
         low_r <= low_r + 5'h01;
   end

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   erase_thr_a: assert property (bulk_erase |=> bor_thr_sel == THR_LOWEST && bor_det_enable)
      else $error("erase did not force detector");
   erase_keep_a: assert property (bulk_erase && sys_reset_n |=> sys_reset_n)
      else $error("reset during erase");
   erase_abort_a: assert property ((low_power_brownout && bulk_erase)[*3] |-> ##[0:2] erase_abort)
      else $error("erase not aborted");
   lp_reset_a: assert property ((low_power_brownout && !bulk_erase)[*2] |-> ##[0:2] !sys_reset_n)
      else $error("low power trip ignored");
   short_dip_a: assert property ($fell(sys_reset_n) |-> $past(low_r, 2) >= BOR_FILTER_CYC
      || $past(low_power_brownout))
      else $error("reset without long low supply");
   long_low_a: assert property (low_r == 5'h16 && !$past(bulk_erase) |-> !sys_reset_n)
      else $error("long low supply without reset");
   boot_gate_a: assert property ($rose(sys_reset_n) && $past(mode_r[1])
      |-> $past(bor_det_ready) && !$past(bor_below_thr))
      else $error("start-up did not wait");
   wake_fast_a: assert property (!cpu_run && sys_reset_n && wake_req && mode_r != MODE_NOSLEEP
      && low_r == 5'h00 && !low_power_brownout && !$past(low_power_brownout) |=> cpu_run)
      else $error("wake-up delayed");
   sw_en_a: assert property (mode_r == MODE_SW && !bulk_erase
      |=> bor_det_enable == $past(swen_r) && bor_det_hibernate != $past(swen_r))
      else $error("software enable not followed");

   cover property ($rose(cpu_run));
   cover property (erase_abort);
   cover property ($fell(sys_reset_n));
endmodule

bind brc_brownout_reset_control brc_chk u_brc_chk (.*);

// ===== tb/brc_supply_model.sv
module brc_supply_model
   import brc_pkg::*;
#(
   parameter int RDY_DLY = 4
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control and supply levels
   input wire logic bor_det_enable,
   input wire logic supply_low,
   input wire logic lp_low,
   // Detector outputs
   output logic bor_below_thr,
   output logic bor_det_ready,
   output logic low_power_brownout
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] warm_r;
   logic tog_r;

   // Detector settles some cycles after enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         warm_r <= 4'h0;
      else if (!bor_det_enable)
         warm_r <= 4'h0;
      else if (warm_r != 4'(RDY_DLY))
         warm_r <= warm_r + 4'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tog_r <= 1'b0;
      else
         tog_r <= ~tog_r;
   end

   assign bor_det_ready = (warm_r == 4'(RDY_DLY));
   // Comparator output is junk while off
   assign bor_below_thr = bor_det_enable ? supply_low : tog_r;
   assign low_power_brownout = lp_low;
endmodule

// ===== tb/testbench.sv
module testbench
   import brc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic supply_low, lp_low, bor_below_thr, bor_det_ready, low_power_brownout;
   logic bor_det_enable, bor_det_hibernate, sleep_req, wake_req, bulk_erase;
   logic erase_abort, cpu_run, sys_reset_n;
   logic [THR_W-1:0] bor_thr_sel;
   // Mode, sw enable, expected enable, expected hibernate
   logic [4:0] rows[5] = '{5'b11010, 5'b10010, 5'b01110, 5'b01001, 5'b00100};
   logic [1:0] wm[3] = '{MODE_ON, MODE_NOSLEEP, MODE_SW};
   int error_cnt = 0;
   int compares = 0;

   brc_brownout_reset_control #(.POWER_UP_DELAY_TIMER_CYCLES(10)) u_brc_brownout_reset_control (.*);
   brc_supply_model u_brc_supply_model (.*);

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic results;
      if (error_cnt == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      if (n == 20)
      begin
         error_cnt++;
         results();
      end
      // Answer taken at the edge where pready is sampled high
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_run;
      int n;
      n = 0;
      while (cpu_run !== 1'b1 && n < 100)
      begin
         n++;
         @(negedge pclk);
      end
      if (n == 100)
      begin
         error_cnt++;
         results();
      end
   endtask

   initial
   begin
      {presetn, psel, penable, pwrite, supply_low, lp_low} = 6'h00;
      {sleep_req, wake_req, bulk_erase} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tick(20);
      presetn <= 1'b1;
      wait_run();
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("ctrl", 32'h00000003, rd);
      apb(1'b0, ADDR_STAT, 32'h0);
      check("stat", 32'h00000036, rd);
      apb(1'b0, 8'h08, 32'h0);
      check("slverr", 32'h1, {31'h0, er});
      foreach (rows[i])
      begin
         apb(1'b1, ADDR_CTRL, {29'h0, rows[i][2], rows[i][4:3]});
         tick(8);
         @(negedge pclk);
         check("enable", {31'h0, rows[i][1]}, {31'h0, bor_det_enable});
         check("hibernate", {31'h0, rows[i][0]}, {31'h0, bor_det_hibernate});
         apb(1'b0, ADDR_STAT, 32'h0);
         check("ready", {31'h0, rows[i][1]}, {31'h0, rd[STAT_RDY_BIT]});
      end
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b1, ADDR_STAT, 32'h3);
      tick(8);
      supply_low <= 1'b1;
      tick(15);
      supply_low <= 1'b0;
      tick(3);
      @(negedge pclk);
      check("dip", 32'h1, {31'h0, sys_reset_n});
      tick(1);
      supply_low <= 1'b1;
      tick(25);
      @(negedge pclk);
      check("brownout", 32'h0, {31'h0, sys_reset_n});
      tick(1);
      supply_low <= 1'b0;
      wait_run();
      apb(1'b0, ADDR_STAT, 32'h0);
      check("bor_flag", 32'h00000035, rd);
      foreach (wm[i])
      begin
         apb(1'b1, ADDR_CTRL, {29'h0, wm[i] == MODE_SW, wm[i]});
         tick(8);
         sleep_req <= 1'b1;
         tick(1);
         sleep_req <= 1'b0;
         tick(2);
         @(negedge pclk);
         check("sleep_hib", {31'h0, wm[i] == MODE_NOSLEEP}, {31'h0, bor_det_hibernate});
         @(posedge pclk);
         wake_req <= 1'b1;
         tick(1);
         wake_req <= 1'b0;
         @(negedge pclk);
         check("wake", {31'h0, wm[i] != MODE_NOSLEEP}, {31'h0, cpu_run});
         wait_run();
      end
      apb(1'b1, ADDR_CTRL, 32'h1B);
      bulk_erase <= 1'b1;
      tick(2);
      @(negedge pclk);
      check("erase_thr", 32'h0, {30'h0, bor_thr_sel});
      @(posedge pclk);
      lp_low <= 1'b1;
      tick(4);
      lp_low <= 1'b0;
      @(negedge pclk);
      check("erase_abort", 32'h1, {31'h0, erase_abort});
      tick(3);
      bulk_erase <= 1'b0;
      @(negedge pclk);
      check("erase_rst", 32'h1, {31'h0, sys_reset_n});
      apb(1'b0, ADDR_STAT, 32'h0);
      check("abort", 32'h0000003D, rd);
      apb(1'b1, ADDR_CTRL, 32'h0);
      lp_low <= 1'b1;
      tick(3);
      lp_low <= 1'b0;
      @(negedge pclk);
      check("lp_reset", 32'h0, {31'h0, sys_reset_n});
      wait_run();
      // Power-up timer: held in reset for POWER_UP_DELAY_TIMER_CYCLES cycles after boot
      apb(1'b1, ADDR_CTRL, 32'h20);
      lp_low <= 1'b1;
      tick(2);
      lp_low <= 1'b0;
      tick(11);
      @(negedge pclk);
      check("power_up_delay_timer_hold", 32'h0, {31'h0, cpu_run});
      tick(1);
      @(negedge pclk);
      check("power_up_delay_timer_done", 32'h1, {31'h0, cpu_run});
      // Mid-run reset clears the power-on flag again
      @(posedge pclk);
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      wait_run();
      apb(1'b0, ADDR_STAT, 32'h0);
      check("rst_stat", 32'h00000036, rd);
      results();
   end
endmodule
